// ### shared/smfl_pkg.sv
// constants, register layout and carrier types for the supply monitor flag logic
// assumes a 40 MHz core clock and an 8-bit special-function register port
package smfl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SMC_ADDR  = 8'hdf;
  localparam logic [7:0] SMC_RESET = 8'hde;

  localparam int BIT_DIG_CMP  = 7;
  localparam int BIT_ANA_CMP  = 6;
  localparam int BIT_FLAG     = 5;
  localparam int BIT_DTRIP_HI = 4;
  localparam int BIT_DTRIP_LO = 3;
  localparam int BIT_ATRIP_HI = 2;
  localparam int BIT_ATRIP_LO = 1;
  localparam int BIT_ON       = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_FREQ_HZ      = 64'd40_000_000;
  localparam longint unsigned RECOVERY_TIME_MS = 64'd250;
  localparam longint unsigned RECOVERY_CYCLES  = RECOVERY_TIME_MS * CLK_FREQ_HZ / 64'd1000;
  localparam int              RECOVERY_CNT_W   = 24;
  localparam longint unsigned FILTER_TIME_NS   = 64'd1000;
  localparam longint unsigned FILTER_CYCLES    =
    (FILTER_TIME_NS * CLK_FREQ_HZ + 64'd999_999_999) / 64'd1_000_000_000;
  localparam int              FILTER_CNT_W     = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // trip point codes: 4.63 V, 3.08 V, 2.93 V, 2.63 V
  typedef enum logic [1:0] {
    SMFL_TRIP_4V63 = 2'h0,
    SMFL_TRIP_3V08 = 2'h1,
    SMFL_TRIP_2V93 = 2'h2,
    SMFL_TRIP_2V63 = 2'h3
  } smfl_trip_t;

  typedef enum logic [2:0] {
    SMFL_WATCH   = 3'b001,
    SMFL_LOW     = 3'b010,
    SMFL_RECOVER = 3'b100
  } smfl_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } smfl_sfr_req_t;

endpackage

// ### verification/smfl_supply_model.sv
// behavioural pair of supply comparators feeding the monitor
// assumes the bench calls dip between clock edges, one supply at a time
`timescale 1ns/1ps
module smfl_supply_model
(
  input  wire logic clk,
  output logic      dig_ok,
  output logic      ana_ok
);
  initial
  begin
    dig_ok = 1'b1;
    ana_ok = 1'b1;
  end

  // one supply below its trip point for n cycles
  task automatic dip(input bit ana, input int n);
    @(negedge clk);
    if (ana)
      ana_ok = 1'b0;
    else
      dig_ok = 1'b0;
    repeat (n) @(negedge clk);
    ana_ok = 1'b1;
    dig_ok = 1'b1;
  endtask
endmodule

// ### verification/smfl_top_bench.sv
// self-checking bench for the supply monitor flag logic
// assumes the comparator model drives both raw comparator inputs
`timescale 1ns/1ps
module smfl_top_bench
  import smfl_pkg::*;
();
  localparam int REC = 100;
  logic          clk;
  logic          reset_n;
  logic          dig;
  logic          ana;
  logic          ien;
  logic          irq;
  logic          mon;
  logic [7:0]    rdata;
  logic [1:0]    dts;
  logic [1:0]    ats;
  smfl_sfr_req_t req;
  logic [7:0]    expq[$];
  logic          rd_q;
  logic [31:0]   lfsr;
  int            failures;
  int            checks;
  int            cyc;

  smfl_top #(.RECOVERY_LEN(REC)) i_smfl_top (
    .clk(clk), .reset_n(reset_n), .sfr_req(req), .sfr_rdata(rdata),
    .digital_cmp_in(dig), .analog_cmp_in(ana),
    .secondary_interrupt_enable_priority(ien), .low_supply_irq(irq),
    .supply_monitor_on(mon), .digital_trip_sel(dts), .analog_trip_sel(ats));

  smfl_supply_model i_smfl_supply_model (.clk(clk), .dig_ok(dig), .ana_ok(ana));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic acc(input logic [7:0] a, input bit w, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(a, 1'b0, 8'h00);
  endtask

  // read data watcher
  always @(posedge clk) rd_q <= req.rd;
  always @(negedge clk)
  begin
    cyc++;
    if (rd_q === 1'b1)
      check("sfr_rdata", rdata, expq.pop_front());
    if (cyc > 20000)
    begin
      failures++;
      stop_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    req = '0;
    ien = 1'b1;
    lfsr = 32'habda86f3;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    rd(8'hdf, 8'hde);
    check("irq", {7'h0, irq}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      acc(8'hdf, 1'b1, 8'(i * 10 + 1));
      check("trip_sel", {4'h0, dts, ats}, 8'(i * 5));
      check("monitor_on", {7'h0, mon}, 8'h01);
      rd(8'hdf, 8'(8'hc1 + i * 10));
    end
    rd(8'hde, 8'h00);
    acc(8'hde, 1'b1, 8'h00);
    rd(8'hdf, 8'hdf);
    acc(8'hdf, 1'b1, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      i_smfl_supply_model.dip(lfsr[5], 5 + int'(lfsr[4:0]));
      repeat (50) @(negedge clk);
      check("irq", {7'h0, irq}, 8'h00);
      rd(8'hdf, 8'hc1);
    end
    fork
      i_smfl_supply_model.dip(1'b0, 100);
      begin
        repeat (60) @(negedge clk);
        rd(8'hdf, 8'h61);
        check("irq", {7'h0, irq}, 8'h01);
        acc(8'hdf, 1'b1, 8'h01);
        rd(8'hdf, 8'h61);
        ien = 1'b0;
        @(negedge clk);
        check("irq", {7'h0, irq}, 8'h00);
      end
    join
    repeat (50) @(negedge clk);
    fork
      i_smfl_supply_model.dip(1'b1, 60);
      begin
        repeat (55) @(negedge clk);
        rd(8'hdf, 8'ha1);
      end
    join
    repeat (60) @(negedge clk);
    rd(8'hdf, 8'he1);
    repeat (100) @(negedge clk);
    rd(8'hdf, 8'hc1);
    acc(8'hdf, 1'b1, 8'h00);
    check("monitor_on", {7'h0, mon}, 8'h00);
    i_smfl_supply_model.dip(1'b0, 100);
    rd(8'hdf, 8'h40);
    repeat (50) @(negedge clk);
    acc(8'hdf, 1'b1, 8'h20);
    rd(8'hdf, 8'he0);
    acc(8'hdf, 1'b1, 8'h00);
    rd(8'hdf, 8'hc0);
    stop_test();
  end
endmodule

// ### verilog/smfl_glitch_filter.sv
// two-flop synchroniser and stability filter for one comparator input
// assumes the raw comparator level is asynchronous to clk
`timescale 1ns/1ps
module smfl_glitch_filter
  import smfl_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic raw_in,
  output logic      filt_out
);

  logic                    sync1_q;
  logic                    sync2_q;
  logic [FILTER_CNT_W-1:0] cnt_q;
  logic                    filt_q;

  localparam logic [FILTER_CNT_W-1:0] CNT_LAST = FILTER_CNT_W'(FILTER_CYCLES - 64'd1);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // level must differ for the whole window before it is accepted
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= '0;
      filt_q <= 1'b1;
    end
    else if (sync2_q == filt_q)
    begin
      cnt_q <= '0;
    end
    else if (cnt_q == CNT_LAST)
    begin
      cnt_q  <= '0;
      filt_q <= sync2_q;
    end
    else
    begin
      cnt_q <= cnt_q + FILTER_CNT_W'(1);
    end
  end

  assign filt_out = filt_q;

  chk_filter_hold_time: assert property (
    @(posedge clk) disable iff (!reset_n)
    (filt_q != $past(filt_q)) |-> ($past(sync2_q) == filt_q) && ($past(cnt_q) == CNT_LAST))
    else $error("filtered level changed before the window elapsed");

endmodule

// ### verilog/smfl_top.sv
// supply monitor flag logic: control register, low-supply flag and recovery timer
// assumes raw comparator levels from the analog side and an 8-bit core register port
//
// Functional notes
// - comparators raise flag only while monitor enabled
// - either comparator low sets bit 5 flag
// - both high for 250 ms after a low, with monitor on, clears flag
// - software flag writes; clear ignored while low
// - bit 7 is live digital comparator state
// - bit 6 is live analog comparator state
// - bits 4:3 select digital trip point
// - bits 2:1 select analog trip point
// - bit 0 switches monitor on/off
// - interrupt only when core enable set
// - comparator glitches filtered before flag logic
`timescale 1ns/1ps
module smfl_top
  import smfl_pkg::*;
#(
  parameter int unsigned RECOVERY_LEN = 32'(RECOVERY_CYCLES)
)
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire smfl_sfr_req_t  sfr_req,
  output logic [7:0]          sfr_rdata,
  input  wire logic           digital_cmp_in,
  input  wire logic           analog_cmp_in,
  input  wire logic           secondary_interrupt_enable_priority,
  output logic                low_supply_irq,
  output logic                supply_monitor_on,
  output logic [1:0]          digital_trip_sel,
  output logic [1:0]          analog_trip_sel
);

  localparam logic [RECOVERY_CNT_W-1:0] REC_LAST = RECOVERY_CNT_W'(RECOVERY_LEN - 1);

  // ----------------------------------------------------------------
  // comparator filtering
  // ----------------------------------------------------------------
  logic digital_supply_compare_state;
  logic analog_supply_compare_state;

  smfl_glitch_filter u_dig_filter (
    .clk      (clk),
    .reset_n  (reset_n),
    .raw_in   (digital_cmp_in),
    .filt_out (digital_supply_compare_state)
  );

  smfl_glitch_filter u_ana_filter (
    .clk      (clk),
    .reset_n  (reset_n),
    .raw_in   (analog_cmp_in),
    .filt_out (analog_supply_compare_state)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic                      on_q;
  logic [1:0]                dtrip_q;
  logic [1:0]                atrip_q;
  logic                      flag_q;
  logic                      flag_d;
  logic                      irq_q;
  logic [7:0]                rdata_q;
  smfl_state_t               state_q;
  smfl_state_t               state_d;
  logic [RECOVERY_CNT_W-1:0] cnt_q;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      any_low;
  logic                      hw_set;
  logic                      expire;
  logic [7:0]                reg_view;

  assign wr_hit  = sfr_req.wr && (sfr_req.addr == SMC_ADDR);
  assign rd_hit  = sfr_req.rd && (sfr_req.addr == SMC_ADDR);
  assign any_low = !(digital_supply_compare_state && analog_supply_compare_state);
  assign hw_set  = on_q && any_low;
  assign expire  = on_q && (state_q == SMFL_RECOVER) && !any_low && (cnt_q == REC_LAST);

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_q    <= SMC_RESET[BIT_ON];
      dtrip_q <= SMC_RESET[BIT_DTRIP_HI:BIT_DTRIP_LO];
      atrip_q <= SMC_RESET[BIT_ATRIP_HI:BIT_ATRIP_LO];
    end
    else if (wr_hit)
    begin
      on_q    <= sfr_req.wdata[BIT_ON];
      dtrip_q <= sfr_req.wdata[BIT_DTRIP_HI:BIT_DTRIP_LO];
      atrip_q <= sfr_req.wdata[BIT_ATRIP_HI:BIT_ATRIP_LO];
    end
  end

  // ----------------------------------------------------------------
  // recovery sequence
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    if (!on_q)
    begin
      state_d = SMFL_WATCH;
    end
    else
    begin
      unique case (state_q)
        SMFL_WATCH:   if (any_low) state_d = SMFL_LOW;
        SMFL_LOW:     if (!any_low) state_d = SMFL_RECOVER;
        SMFL_RECOVER:
        begin
          if (any_low)
            state_d = SMFL_LOW;
          else if (cnt_q == REC_LAST)
            state_d = SMFL_WATCH;
        end
        default:      state_d = SMFL_WATCH;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= SMFL_WATCH;
    else
      state_q <= state_d;
  end

  // counts only while recovering with both supplies high
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_q <= '0;
    else if (state_q == SMFL_RECOVER && state_d == SMFL_RECOVER)
      cnt_q <= cnt_q + RECOVERY_CNT_W'(1);
    else
      cnt_q <= '0;
  end

  // ----------------------------------------------------------------
  // low-supply flag
  // ----------------------------------------------------------------
  always_comb
  begin
    flag_d = flag_q;
    if (hw_set)
      flag_d = 1'b1;
    else if (wr_hit && !(any_low && !sfr_req.wdata[BIT_FLAG]))
      flag_d = sfr_req.wdata[BIT_FLAG];
    else if (expire)
      flag_d = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_q <= SMC_RESET[BIT_FLAG];
    else
      flag_q <= flag_d;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_q <= 1'b0;
    else
      irq_q <= flag_q && secondary_interrupt_enable_priority;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    reg_view                            = '0;
    reg_view[BIT_DIG_CMP]               = digital_supply_compare_state;
    reg_view[BIT_ANA_CMP]               = analog_supply_compare_state;
    reg_view[BIT_FLAG]                  = flag_q;
    reg_view[BIT_DTRIP_HI:BIT_DTRIP_LO] = dtrip_q;
    reg_view[BIT_ATRIP_HI:BIT_ATRIP_LO] = atrip_q;
    reg_view[BIT_ON]                    = on_q;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else if (rd_hit)
      rdata_q <= reg_view;
    else
      rdata_q <= 8'h00;
  end

  assign sfr_rdata         = rdata_q;
  assign low_supply_irq    = irq_q;
  assign supply_monitor_on = on_q;
  assign digital_trip_sel  = dtrip_q;
  assign analog_trip_sel   = atrip_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_off_no_raise: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!on_q && !flag_q && !wr_hit) |=> !flag_q)
    else $error("flag raised while monitor disabled");

  chk_low_sets_flag: assert property (
    @(posedge clk) disable iff (!reset_n)
    (on_q && any_low) |=> flag_q)
    else $error("low comparator did not set flag");

  chk_recover_clears: assert property (
    @(posedge clk) disable iff (!reset_n)
    (expire && !wr_hit) |=> !flag_q && (state_q == SMFL_WATCH))
    else $error("flag not cleared at end of recovery");

  chk_clear_blocked: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wr_hit && !sfr_req.wdata[BIT_FLAG] && any_low && flag_q) |=> flag_q)
    else $error("software cleared flag while supply low");

  chk_read_dig_cmp: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_hit |=> sfr_rdata[BIT_DIG_CMP] == $past(digital_supply_compare_state))
    else $error("digital comparator bit wrong on read");

  chk_read_ana_cmp: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_hit |=> sfr_rdata[BIT_ANA_CMP] == $past(analog_supply_compare_state))
    else $error("analog comparator bit wrong on read");

  chk_trip_fields: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_hit |=> (digital_trip_sel == $past(sfr_req.wdata[4:3]))
            && (analog_trip_sel == $past(sfr_req.wdata[2:1])))
    else $error("trip select outputs do not follow write");

  chk_enable_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_hit |=> supply_monitor_on == $past(sfr_req.wdata[0]))
    else $error("monitor enable does not follow write");

  chk_irq_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    low_supply_irq == ($past(flag_q) && $past(secondary_interrupt_enable_priority)))
    else $error("interrupt not gated by core enable");

  chk_restart_count: assert property (
    @(posedge clk) disable iff (!reset_n)
    (on_q && state_q == SMFL_RECOVER && any_low) |=> (state_q == SMFL_LOW) && (cnt_q == '0))
    else $error("recovery count not abandoned on low supply");

endmodule
